/* File: logic/touch_cfg_pkg.sv */
package touch_cfg_pkg;
  localparam logic [3:0] OFS_TOUCH_CFG = 4'h5;
  localparam logic [3:0] OFS_TEMP_HI = 4'h6;
  localparam logic [3:0] OFS_TEMP_LO = 4'h7;
  localparam logic [3:0] OFS_AUX_HI = 4'h8;
  localparam logic [3:0] OFS_AUX_LO = 4'h9;
  localparam int PEN_DIS_BIT = 6;
  localparam int PRE_LSB = 3;
  localparam int SENSE_LSB = 0;
  localparam int CHK_EN_BIT = 12;
  localparam logic [15:0] TOUCH_CFG_RST = 16'h0000;
  localparam logic [11:0] UPPER_RST = 12'hFFF;
  localparam logic [11:0] LOWER_RST = 12'h000;
  localparam int CLK_MHZ = 100;
  // Durations in ns, indexed by the 3-bit code
  localparam int PRE_NS [8] = '{20000, 84000, 276000, 340000,
                                1044000, 1108000, 1300000, 1364000};
  localparam int SENSE_NS [8] = '{32000, 96000, 544000, 608000,
                                  2080000, 2144000, 2592000, 2656000};
  localparam int CNT_W = 19;
  // Cycles at 10 ns per cycle
  localparam int PRE_CYC [8] = '{PRE_NS[0]/10, PRE_NS[1]/10, PRE_NS[2]/10,
    PRE_NS[3]/10, PRE_NS[4]/10, PRE_NS[5]/10, PRE_NS[6]/10, PRE_NS[7]/10};
  localparam int SENSE_CYC [8] = '{SENSE_NS[0]/10, SENSE_NS[1]/10,
    SENSE_NS[2]/10, SENSE_NS[3]/10, SENSE_NS[4]/10, SENSE_NS[5]/10,
    SENSE_NS[6]/10, SENSE_NS[7]/10};
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_PRECHARGE = 2'b01,
    TS_SENSE = 2'b11
  } touch_state_e;
endpackage

/* File: logic/limit_check.sv */
`timescale 1ns/100ps
// One window comparator on a 12-bit code
module limit_check (
  input wire logic [11:0] code,
  input wire logic [11:0] upper,
  input wire logic [11:0] lower,
  input wire logic upper_en,
  input wire logic lower_en,
  output logic over_upper,
  output logic hit_upper,
  output logic hit_lower
);
  assign over_upper = code >= upper;
  assign hit_upper = upper_en && over_upper;
  assign hit_lower = lower_en && (code <= lower);
endmodule

/* File: logic/touch_config_threshold_monitor.sv */
// Behaviour
// - Disable bit high stops pen detection
// - Precharge code selects one of eight durations
// - Precharge full duration before sensing touch
// - Sense code selects one of eight waits
// - Temperature upper check only when enabled
// - Temperature code at/above upper raises interrupt
// - Temperature lower check only when enabled
// - Temperature code at/below lower raises interrupt
// - Temperature limits use selected sensor only
// - Aux upper check only when enabled
// - Aux code at/above upper raises interrupt
// - Aux lower check only when enabled
// - Aux code at/below lower raises interrupt
// - Over-max flag tracks temperature against limit
// - Source select picks sensor one or two in auto-scan only
`timescale 1ns/100ps
module touch_config_threshold_monitor (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic auto_scan,
  input wire logic temp_source_sel,
  input wire logic [3:0] conversion_mode_sel,
  input wire logic conv_valid,
  input wire logic [1:0] conv_src,
  input wire logic [11:0] conv_code,
  input wire logic touch_start,
  input wire logic pen_level,
  output logic pen_detect_en,
  output logic precharge_on,
  output logic sense_on,
  output logic touch_seen,
  output logic touch_done,
  output logic temp_over_max_flag,
  output logic limit_irq
);
  // conv_src: 0 = temp_sensor_one, 1 = temp_sensor_two, 2 = aux_input_one
  // conversion_mode_sel codes for sensor one and two in non-auto-scan
  localparam logic [3:0] MODE_TEMP_ONE = 4'hA;
  localparam logic [3:0] MODE_TEMP_TWO = 4'hC;

  logic pen_detect_disable_r;
  logic [2:0] precharge_time_sel_r;
  logic [2:0] sense_time_sel_r;
  logic temp_max_check_en_r;
  logic temp_min_check_en_r;
  logic aux_one_max_check_en_r;
  logic aux_one_min_check_en_r;
  logic [11:0] temp_upper_limit_val_r;
  logic [11:0] temp_lower_limit_val_r;
  logic [11:0] aux_one_upper_limit_val_r;
  logic [11:0] aux_one_lower_limit_val_r;
  logic pen_sync1_r;
  logic pen_sync2_r;
  touch_cfg_pkg::touch_state_e state_r;
  touch_cfg_pkg::touch_state_e state_nxt;
  // Wide enough for the longest sense wait in cycles
  logic [touch_cfg_pkg::CNT_W-1:0] cnt_r;
  logic [touch_cfg_pkg::CNT_W-1:0] cnt_nxt;

  function automatic logic [15:0] limit_word(input logic en,
                                              input logic [11:0] val);
    limit_word = {3'h0, en, val};
  endfunction

  function automatic logic [touch_cfg_pkg::CNT_W-1:0] pre_cycles(
      input logic [2:0] sel);
    pre_cycles = touch_cfg_pkg::CNT_W'(touch_cfg_pkg::PRE_CYC[sel]);
  endfunction

  function automatic logic [touch_cfg_pkg::CNT_W-1:0] sense_cycles(
      input logic [2:0] sel);
    sense_cycles = touch_cfg_pkg::CNT_W'(touch_cfg_pkg::SENSE_CYC[sel]);
  endfunction

  // Register decode, shared by the write strobes and the read mux
  wire sel_cfg = (reg_addr == touch_cfg_pkg::OFS_TOUCH_CFG);
  wire sel_thi = (reg_addr == touch_cfg_pkg::OFS_TEMP_HI);
  wire sel_tlo = (reg_addr == touch_cfg_pkg::OFS_TEMP_LO);
  wire sel_ahi = (reg_addr == touch_cfg_pkg::OFS_AUX_HI);
  wire sel_alo = (reg_addr == touch_cfg_pkg::OFS_AUX_LO);

  wire wr_cfg = reg_wr && sel_cfg;
  wire wr_thi = reg_wr && sel_thi;
  wire wr_tlo = reg_wr && sel_tlo;
  wire wr_ahi = reg_wr && sel_ahi;
  wire wr_alo = reg_wr && sel_alo;
  wire [15:0] cfg_word = {9'h000, pen_detect_disable_r,
                          precharge_time_sel_r, sense_time_sel_r};
  logic [15:0] rd_mux;
  always_comb begin
    if (sel_cfg) begin
      rd_mux = cfg_word;
    end else if (sel_thi) begin
      rd_mux = limit_word(temp_max_check_en_r, temp_upper_limit_val_r);
    end else if (sel_tlo) begin
      rd_mux = limit_word(temp_min_check_en_r, temp_lower_limit_val_r);
    end else if (sel_ahi) begin
      rd_mux = limit_word(aux_one_max_check_en_r, aux_one_upper_limit_val_r);
    end else if (sel_alo) begin
      rd_mux = limit_word(aux_one_min_check_en_r, aux_one_lower_limit_val_r);
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pen_detect_disable_r <= touch_cfg_pkg::TOUCH_CFG_RST[6];
      precharge_time_sel_r <= touch_cfg_pkg::TOUCH_CFG_RST[5:3];
      sense_time_sel_r <= touch_cfg_pkg::TOUCH_CFG_RST[2:0];
    end else if (wr_cfg) begin
      pen_detect_disable_r <= reg_wdata[touch_cfg_pkg::PEN_DIS_BIT];
      precharge_time_sel_r <= reg_wdata[touch_cfg_pkg::PRE_LSB +: 3];
      sense_time_sel_r <= reg_wdata[touch_cfg_pkg::SENSE_LSB +: 3];
    end
  end

  // Limit words: check enable above a 12-bit limit value
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_max_check_en_r <= 1'b0;
      temp_upper_limit_val_r <= touch_cfg_pkg::UPPER_RST;
    end else if (wr_thi) begin
      temp_max_check_en_r <= reg_wdata[touch_cfg_pkg::CHK_EN_BIT];
      temp_upper_limit_val_r <= reg_wdata[11:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_min_check_en_r <= 1'b0;
      temp_lower_limit_val_r <= touch_cfg_pkg::LOWER_RST;
    end else if (wr_tlo) begin
      temp_min_check_en_r <= reg_wdata[touch_cfg_pkg::CHK_EN_BIT];
      temp_lower_limit_val_r <= reg_wdata[11:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_one_max_check_en_r <= 1'b0;
      aux_one_upper_limit_val_r <= touch_cfg_pkg::UPPER_RST;
    end else if (wr_ahi) begin
      aux_one_max_check_en_r <= reg_wdata[touch_cfg_pkg::CHK_EN_BIT];
      aux_one_upper_limit_val_r <= reg_wdata[11:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_one_min_check_en_r <= 1'b0;
      aux_one_lower_limit_val_r <= touch_cfg_pkg::LOWER_RST;
    end else if (wr_alo) begin
      aux_one_min_check_en_r <= reg_wdata[touch_cfg_pkg::CHK_EN_BIT];
      aux_one_lower_limit_val_r <= reg_wdata[11:0];
    end
  end

  // Temperature sensor choice
  wire sel_sensor = auto_scan ? temp_source_sel :
                    (conversion_mode_sel == MODE_TEMP_TWO);
  wire mode_is_temp = (conversion_mode_sel == MODE_TEMP_ONE) ||
                      (conversion_mode_sel == MODE_TEMP_TWO);
  wire src_is_temp = (conv_src == {1'b0, sel_sensor}) &&
                     (auto_scan || mode_is_temp);
  wire src_is_aux = (conv_src == 2'h2);

  logic t_over;
  logic t_hi;
  logic t_lo;
  logic a_hi;
  logic a_lo;

  limit_check u_temp_chk (
    .code(conv_code),
    .upper(temp_upper_limit_val_r),
    .lower(temp_lower_limit_val_r),
    .upper_en(temp_max_check_en_r),
    .lower_en(temp_min_check_en_r),
    .over_upper(t_over),
    .hit_upper(t_hi),
    .hit_lower(t_lo)
  );

  limit_check u_aux_chk (
    .code(conv_code),
    .upper(aux_one_upper_limit_val_r),
    .lower(aux_one_lower_limit_val_r),
    .upper_en(aux_one_max_check_en_r),
    .lower_en(aux_one_min_check_en_r),
    .over_upper(),
    .hit_upper(a_hi),
    .hit_lower(a_lo)
  );

  // Gated checks only; a disabled limit never fires
  wire temp_hit = conv_valid && src_is_temp && (t_hi || t_lo);
  wire aux_hit = conv_valid && src_is_aux && (a_hi || a_lo);

  // Flag follows the raw compare; the enables gate only the interrupt
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      limit_irq <= 1'b0;
      temp_over_max_flag <= 1'b0;
    end else begin
      limit_irq <= temp_hit || aux_hit;
      if (conv_valid && src_is_temp) begin
        temp_over_max_flag <= t_over;
      end
    end
  end

  // Pen sense synchroniser
  // Only the second stage is read; the first may go metastable
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pen_sync1_r <= 1'b0;
      pen_sync2_r <= 1'b0;
    end else begin
      pen_sync1_r <= pen_level;
      pen_sync2_r <= pen_sync1_r;
    end
  end

  // Touch detect sequencer
  // Disable aborts either phase and drops the count
  wire start_ok = touch_start && !pen_detect_disable_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      touch_cfg_pkg::TS_IDLE: begin
        if (start_ok) begin
          state_nxt = touch_cfg_pkg::TS_PRECHARGE;
          cnt_nxt = pre_cycles(precharge_time_sel_r) - 1'b1;
        end
      end
      touch_cfg_pkg::TS_PRECHARGE: begin
        if (pen_detect_disable_r) begin
          state_nxt = touch_cfg_pkg::TS_IDLE;
          cnt_nxt = '0;
        end else if (cnt_r == '0) begin
          state_nxt = touch_cfg_pkg::TS_SENSE;
          cnt_nxt = sense_cycles(sense_time_sel_r) - 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      touch_cfg_pkg::TS_SENSE: begin
        if (pen_detect_disable_r || cnt_r == '0) begin
          state_nxt = touch_cfg_pkg::TS_IDLE;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = touch_cfg_pkg::TS_IDLE;
      end
    endcase
  end

  wire sense_end = (state_r == touch_cfg_pkg::TS_SENSE) && (cnt_r == '0) &&
                   !pen_detect_disable_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= touch_cfg_pkg::TS_IDLE;
      cnt_r <= '0;
      precharge_on <= 1'b0;
      sense_on <= 1'b0;
      touch_done <= 1'b0;
      touch_seen <= 1'b0;
      pen_detect_en <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      precharge_on <= state_nxt == touch_cfg_pkg::TS_PRECHARGE;
      sense_on <= state_nxt == touch_cfg_pkg::TS_SENSE;
      touch_done <= sense_end;
      pen_detect_en <= !pen_detect_disable_r;
      if (sense_end) begin
        touch_seen <= pen_sync2_r;
      end
    end
  end
endmodule

/* File: sim/touch_panel_model.sv */
`timescale 1ns/100ps
module touch_panel_model (
  input wire logic touched,
  input wire logic sense_on,
  output logic pen_level
);
  // Pin is pulled low outside sensing, so a stale level never shows
  assign pen_level = sense_on & touched;
endmodule

/* File: sim/touch_monitor_checker.sv */
`timescale 1ns/100ps
module touch_monitor_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input wire logic conv_valid,
  input wire logic touch_start,
  input logic pen_detect_en,
  input logic precharge_on,
  input logic sense_on,
  input logic touch_done,
  input logic temp_over_max_flag,
  input logic limit_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [6:0] cfg_r;
  logic [touch_cfg_pkg::CNT_W-1:0] pre_r;
  logic [touch_cfg_pkg::CNT_W-1:0] sen_r;
  // Shadow of the timing fields, so phase lengths can be judged
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= 7'h00;
      pre_r <= '0;
      sen_r <= '0;
    end else begin
      if (reg_wr && reg_addr == touch_cfg_pkg::OFS_TOUCH_CFG) begin
        cfg_r <= reg_wdata[6:0];
      end
      pre_r <= precharge_on ? pre_r + 1'b1 : '0;
      sen_r <= sense_on ? sen_r + 1'b1 : '0;
    end
  end
  sequence s_pre_end;
    $fell(precharge_on) ##0 sense_on;
  endsequence
  property p_pre_len;
    s_pre_end |-> pre_r == touch_cfg_pkg::PRE_CYC[cfg_r[5:3]];
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("precharge length");
  property p_sen_len;
    $fell(sense_on) |-> sen_r == touch_cfg_pkg::SENSE_CYC[cfg_r[2:0]];
  endproperty
  a_sen_len: assert property (p_sen_len) else $error("sense length");
  property p_sense_order;
    $rose(sense_on) |-> $past(precharge_on);
  endproperty
  a_sense_order: assert property (p_sense_order) else $error("no precharge");
  property p_done;
    touch_done |-> $past(sense_on) && !precharge_on;
  endproperty
  a_done: assert property (p_done) else $error("done out of sense");
  property p_irq;
    limit_irq |-> $past(conv_valid);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without conversion");
  property p_flag;
    $changed(temp_over_max_flag) |-> $past(conv_valid);
  endproperty
  a_flag: assert property (p_flag) else $error("flag moved alone");
  property p_start;
    $rose(precharge_on) |->
      $past(touch_start) && !$past(cfg_r[touch_cfg_pkg::PEN_DIS_BIT]);
  endproperty
  a_start: assert property (p_start) else $error("start while off");
  property p_off;
    reg_wr && reg_addr == touch_cfg_pkg::OFS_TOUCH_CFG &&
      reg_wdata[touch_cfg_pkg::PEN_DIS_BIT] |-> ##[1:2] !pen_detect_en;
  endproperty
  a_off: assert property (p_off) else $error("detect still on");
  property p_rsvd;
    $past(reg_rd) |-> reg_rdata[15:13] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule
bind touch_config_threshold_monitor touch_monitor_checker u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .conv_valid(conv_valid), .touch_start(touch_start),
  .pen_detect_en(pen_detect_en), .precharge_on(precharge_on),
  .sense_on(sense_on), .touch_done(touch_done),
  .temp_over_max_flag(temp_over_max_flag), .limit_irq(limit_irq));

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic ref_clk, rst_b, reg_wr, reg_rd, auto_scan, temp_source_sel;
  logic conv_valid, touch_start, touched, pen_level, pen_detect_en;
  logic [3:0] reg_addr, conversion_mode_sel;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] conv_src;
  logic [11:0] conv_code;
  logic precharge_on, sense_on, touch_seen, touch_done, flag, limit_irq;
  int err_count, samples_checked, cycles;
  touch_config_threshold_monitor u_touch_config_threshold_monitor (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .auto_scan(auto_scan), .temp_source_sel(temp_source_sel),
    .conversion_mode_sel(conversion_mode_sel), .conv_valid(conv_valid),
    .conv_src(conv_src), .conv_code(conv_code), .touch_start(touch_start),
    .pen_level(pen_level), .pen_detect_en(pen_detect_en),
    .precharge_on(precharge_on), .sense_on(sense_on),
    .touch_seen(touch_seen), .touch_done(touch_done),
    .temp_over_max_flag(flag), .limit_irq(limit_irq));
  touch_panel_model u_touch_panel_model (.touched(touched),
    .sense_on(sense_on), .pen_level(pen_level));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
    @(negedge ref_clk);
  endtask
  // Result lands on the taking edge and is read at the next negedge
  task automatic conv(input logic [1:0] s, input logic [11:0] c,
                      input logic i, input logic f);
    conv_valid = 1'b1;
    conv_src = s;
    conv_code = c;
    @(negedge ref_clk);
    conv_valid = 1'b0;
    chk({15'h0, limit_irq}, {15'h0, i});
    chk({15'h0, flag}, {15'h0, f});
    @(negedge ref_clk);
  endtask
  task automatic touch(input logic [5:0] cfg, input logic t);
    int np;
    int ns;
    np = 0;
    ns = 0;
    wr(4'h5, {10'h0, cfg});
    touched = t;
    touch_start = 1'b1;
    @(negedge ref_clk);
    touch_start = 1'b0;
    // Precharge already shows at the first negedge after the start
    do begin
      np += precharge_on;
      ns += sense_on;
      @(negedge ref_clk);
    end while (!touch_done && np + ns < 30000);
    chk({15'h0, touch_done}, 16'h0001);
    chk(16'(np), 16'(touch_cfg_pkg::PRE_CYC[cfg[5:3]]));
    chk(16'(ns), 16'(touch_cfg_pkg::SENSE_CYC[cfg[2:0]]));
    chk({15'h0, touch_seen}, {15'h0, t});
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, auto_scan, temp_source_sel} = 5'h00;
    {conv_valid, touch_start, touched} = 3'h0;
    {reg_addr, conversion_mode_sel, conv_src} = 10'h000;
    {reg_wdata, conv_code} = 28'h0000000;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    chk({15'h0, pen_detect_en}, 16'h0001);
    rd(4'h5, 16'h0000);
    rd(4'h6, 16'h0FFF);
    rd(4'h7, 16'h0000);
    rd(4'h8, 16'h0FFF);
    rd(4'h9, 16'h0000);
    rd(4'h4, 16'h0000);
    wr(4'h6, 16'hFFFF);
    rd(4'h6, 16'h1FFF);
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h007F);
    auto_scan = 1'b1;
    wr(4'h6, 16'h1800);
    conv(2'h0, 12'h800, 1'b1, 1'b1);
    conv(2'h0, 12'h7FF, 1'b0, 1'b0);
    conv(2'h1, 12'h900, 1'b0, 1'b0);
    temp_source_sel = 1'b1;
    conv(2'h1, 12'h900, 1'b1, 1'b1);
    conv(2'h0, 12'h7FF, 1'b0, 1'b1);
    wr(4'h6, 16'h0800);
    conv(2'h1, 12'h900, 1'b0, 1'b1);
    wr(4'h7, 16'h1100);
    conv(2'h1, 12'h100, 1'b1, 1'b0);
    conv(2'h1, 12'h101, 1'b0, 1'b0);
    auto_scan = 1'b0;
    conversion_mode_sel = 4'hA;
    conv(2'h0, 12'h0FF, 1'b1, 1'b0);
    conv(2'h1, 12'h050, 1'b0, 1'b0);
    conversion_mode_sel = 4'hC;
    conv(2'h1, 12'h050, 1'b1, 1'b0);
    conversion_mode_sel = 4'h0;
    conv(2'h0, 12'h050, 1'b0, 1'b0);
    conv(2'h0, 12'h900, 1'b0, 1'b0);
    conversion_mode_sel = 4'hC;
    wr(4'h7, 16'h0100);
    conv(2'h1, 12'h050, 1'b0, 1'b0);
    wr(4'h8, 16'h1FFF);
    conv(2'h2, 12'hFFF, 1'b1, 1'b0);
    conv(2'h2, 12'hFFE, 1'b0, 1'b0);
    wr(4'h8, 16'h0000);
    conv(2'h2, 12'h001, 1'b0, 1'b0);
    wr(4'h9, 16'h1010);
    conv(2'h2, 12'h010, 1'b1, 1'b0);
    conv(2'h2, 12'h011, 1'b0, 1'b0);
    wr(4'h9, 16'h0FFF);
    conv(2'h2, 12'h011, 1'b0, 1'b0);
    touch(6'h00, 1'b1);
    touch(6'h09, 1'b0);
    wr(4'h5, 16'h0000);
    touch_start = 1'b1;
    @(negedge ref_clk);
    touch_start = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({15'h0, precharge_on}, 16'h0001);
    wr(4'h5, 16'h0040);
    chk({15'h0, precharge_on}, 16'h0000);
    chk({15'h0, touch_done}, 16'h0000);
    chk({15'h0, pen_detect_en}, 16'h0000);
    touch_start = 1'b1;
    @(negedge ref_clk);
    touch_start = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({15'h0, precharge_on}, 16'h0000);
    conclude();
  end
endmodule
